// *** verilog/mac_datapath.sv ***
// Purpose: DSP multiplier, scaler, 40-bit adder/subtracter and saturation.
// Assumes: Instruction control presents one request per cycle at most.
// Notes:   All work completes in one cycle; results appear next cycle.
//
// Operation
// RULE1: 17x17 signed/unsigned multiplier; scaler gives 1.31 or integer.
// RULE2: Operands widen to 17 bits by zero fill or sign fill.
// RULE3: Product is 33 bits, sign-extended to 40 bits.
// RULE4: Fractional mode shifts product left once to give 1.31 format.
// RULE5: Fraction range runs from 0x8000 (-1.0) to 0x7fff.
// RULE6: Integer multiply supports signed, unsigned and mixed sign.
// RULE7: Byte operands give 16-bit result, word operands give 32 bits.
// RULE8: 40-bit adder, accumulator A or B is source and destination.
// RULE9: Add and load data pass through an optional barrel shift.
// RULE10: One adder input may be zero, other takes true or inverted data.
// RULE11: Add uses carry active high; subtract inverts data, borrow low.
// RULE12: Overflow out of bit 39 flags catastrophic loss of sign.
// RULE13: Guard overflow flags when guard bits 39..32 disagree.
// RULE14: Overflow and clip flags are latched into the status register.
// RULE15: Clip decision uses result, overflow, per-acc enable and width.
// RULE16: Each accumulator has its own guard overflow flag.
// RULE17: Accumulator A clip flag sets on bit 31 or bit 39 clipping.
// RULE18: Accumulator B clip flag sets under the same conditions.
// RULE19: Combined flags are the OR of both guard and both clip flags.
// RULE20: Guard flags follow only the latest adder operation.
// RULE21: Guard flag with its trap enable raises the arithmetic trap.
// RULE22: Clipping clamps to largest positive or most negative value.
// RULE23: Reset clears flags, control and accumulators synchronously.
`timescale 1ns/1ps
module mac_datapath (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // Instruction control
    input  wire logic                req_valid,
    input  wire mac_pkg::mac_req_type req,
    // Register port
    input  wire logic [7:0]          bus_addr,
    input  wire logic [31:0]         bus_wdata,
    input  wire logic                bus_wr,
    input  wire logic                bus_rd,
    output logic      [31:0]         bus_rdata,
    // Results and status
    output logic      [39:0]         acc_a,
    output logic      [39:0]         acc_b,
    output logic      [31:0]         prod_result,
    output logic                     prod_valid,
    output logic      [7:0]          status_bits,
    output logic                     arith_trap
);
    import mac_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] fit_word(input logic [15:0] v,
                                             input logic        sgn,
                                             input logic        bytem);
        fit_word = bytem ? {{8{sgn & v[7]}}, v[7:0]} : v;
    endfunction : fit_word

    function automatic logic [16:0] widen17(input logic [15:0] v,
                                            input logic        sgn);
        widen17 = {sgn & v[15], v};
    endfunction : widen17

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [39:0] acc_a_r,  acc_a_nxt;
    logic [39:0] acc_b_r,  acc_b_nxt;
    logic [31:0] prod_r,   prod_nxt;
    logic        pvld_r,   pvld_nxt;
    logic [7:0]  ctrl_r,   ctrl_nxt;
    logic [1:0]  trap_en_r, trap_en_nxt;
    logic [7:0]  stat_r,   stat_nxt;
    logic        trap_r,   trap_nxt;
    logic [31:0] rdata_r,  rdata_nxt;

    // ----------------------------------------------------------------
    // Multiplier and scaler
    // ----------------------------------------------------------------
    logic [15:0]        a16, b16;
    logic signed [16:0] ma, mb;
    logic signed [33:0] prod34;
    logic [32:0]        prod33;
    logic [39:0]        prod40;

    always_comb
    begin
        a16    = fit_word(req.opnd_a, req.a_signed, req.byte_mode); // RULE7
        b16    = fit_word(req.opnd_b, req.b_signed, req.byte_mode); // RULE7
        ma     = widen17(a16, req.a_signed);          // RULE2
        mb     = widen17(b16, req.b_signed);          // RULE2
        prod34 = ma * mb;                             // RULE1 RULE6
        // Shifting left once drops the duplicated sign of a Q15 product.
        prod33 = req.frac ? {prod34[31:0], 1'b0}
                          : prod34[32:0];             // RULE4 RULE5
        prod40 = {{7{prod33[32]}}, prod33};           // RULE3
    end

    // ----------------------------------------------------------------
    // Barrel shift and adder
    // ----------------------------------------------------------------
    logic        is_mul_op, is_add_op, zero_acc, do_sub;
    logic [39:0] word40, shifted, src, x_in, y_raw, y_in;
    logic [4:0]  sh_mag;
    logic [40:0] sum41;
    logic        cat_ovf, guard_ovf, ovf31, clip_en, clip_hit;
    logic [39:0] result;

    always_comb
    begin
        is_mul_op = (req.op == OP_MPY) || (req.op == OP_MAC) ||
                    (req.op == OP_MSC);
        is_add_op = req_valid && (is_mul_op || (req.op == OP_ADD) ||
                    (req.op == OP_LOAD_ACC));
        word40 = {{8{req.data[15]}}, req.data, 16'h0000};
        // Negative shift counts move left, positive ones move right.
        sh_mag  = req.shift[4] ? 5'(-req.shift) : req.shift;
        shifted = req.shift[4] ? (word40 << sh_mag)
                               : 40'($signed(word40) >>> sh_mag); // RULE9
        src      = req.acc_sel ? acc_b_r : acc_a_r;   // RULE8
        zero_acc = (req.op == OP_MPY) || (req.op == OP_LOAD_ACC);
        x_in     = zero_acc ? ACC_RST : src;          // RULE10
        y_raw    = is_mul_op ? prod40 : shifted;
        do_sub   = (req.op == OP_MSC);
        y_in     = do_sub ? ~y_raw : y_raw;           // RULE10 RULE11
        // The carry input is a borrow for subtract: high means none.
        sum41 = {x_in[39], x_in} + {y_in[39], y_in}
              + {40'h0000000000, do_sub};             // RULE11
        cat_ovf   = sum41[40] ^ sum41[39];            // RULE12
        guard_ovf = !((&sum41[39:32]) || !(|sum41[39:32])); // RULE13
        ovf31     = !((&sum41[39:31]) || !(|sum41[39:31]));
        clip_en   = req.acc_sel ? ctrl_r[CC_CLIP_B_BIT]
                                : ctrl_r[CC_CLIP_A_BIT];
        result   = sum41[39:0];
        clip_hit = 1'b0;
        // Bit 40 holds the true sign even when bit 39 was overrun.
        if (clip_en && !ctrl_r[CC_WIDTH_BIT] && (ovf31 || cat_ovf))
        begin
            result   = sum41[40] ? NEG31 : POS31;     // RULE15 RULE22
            clip_hit = 1'b1;
        end
        else if (clip_en && ctrl_r[CC_WIDTH_BIT] && cat_ovf)
        begin
            result   = sum41[40] ? NEG39 : POS39;     // RULE15 RULE22
            clip_hit = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        acc_a_nxt   = acc_a_r;
        acc_b_nxt   = acc_b_r;
        prod_nxt    = prod_r;
        pvld_nxt    = 1'b0;
        ctrl_nxt    = ctrl_r;
        trap_en_nxt = trap_en_r;
        stat_nxt    = stat_r;
        rdata_nxt   = 32'h00000000;
        // Software clears clip flags by writing ones; hardware set wins.
        if (bus_wr)
        begin
            if (bus_addr == CORE_CTRL_OFF)
                ctrl_nxt = bus_wdata[7:0];
            else if (bus_addr == INT_CTRL_OFF)
                trap_en_nxt = bus_wdata[1:0];
            else if (bus_addr == STATUS_OFF)
            begin
                stat_nxt[ST_CLIP_A] = stat_r[ST_CLIP_A] &
                                      !bus_wdata[ST_CLIP_A];
                stat_nxt[ST_CLIP_B] = stat_r[ST_CLIP_B] &
                                      !bus_wdata[ST_CLIP_B];
            end
        end
        if (req_valid && (req.op == OP_MUL))
        begin
            prod_nxt = req.byte_mode ? {16'h0000, prod34[15:0]}
                                     : prod34[31:0];  // RULE7
            pvld_nxt = 1'b1;
        end
        if (is_add_op)
        begin
            if (req.acc_sel)
            begin
                acc_b_nxt          = result;          // RULE8
                stat_nxt[ST_OVF_B] = guard_ovf;       // RULE16 RULE20
                stat_nxt[ST_CAT_B] = cat_ovf;         // RULE12
                if (clip_hit)
                    stat_nxt[ST_CLIP_B] = 1'b1;       // RULE18
            end
            else
            begin
                acc_a_nxt          = result;          // RULE8
                stat_nxt[ST_OVF_A] = guard_ovf;       // RULE16 RULE20
                stat_nxt[ST_CAT_A] = cat_ovf;         // RULE12
                if (clip_hit)
                    stat_nxt[ST_CLIP_A] = 1'b1;       // RULE17
            end
        end
        stat_nxt[ST_ANY_OVF]  = stat_nxt[ST_OVF_A] |
                                stat_nxt[ST_OVF_B];   // RULE19
        stat_nxt[ST_ANY_CLIP] = stat_nxt[ST_CLIP_A] |
                                stat_nxt[ST_CLIP_B];  // RULE19
        trap_nxt = (stat_nxt[ST_OVF_A] & trap_en_nxt[IC_TRAP_A_BIT]) |
                   (stat_nxt[ST_OVF_B] &
                    trap_en_nxt[IC_TRAP_B_BIT]);              // RULE21
        if (bus_rd)
        begin
            if (bus_addr == CORE_CTRL_OFF)
                rdata_nxt = {24'h000000, ctrl_r};
            else if (bus_addr == INT_CTRL_OFF)
                rdata_nxt = {30'h00000000, trap_en_r};
            else if (bus_addr == STATUS_OFF)
                rdata_nxt = {24'h000000, stat_r};     // RULE14
            else if (bus_addr == ACCA_LO_OFF)
                rdata_nxt = acc_a_r[31:0];
            else if (bus_addr == ACCA_HI_OFF)
                rdata_nxt = {24'h000000, acc_a_r[39:32]};
            else if (bus_addr == ACCB_LO_OFF)
                rdata_nxt = acc_b_r[31:0];
            else if (bus_addr == ACCB_HI_OFF)
                rdata_nxt = {24'h000000, acc_b_r[39:32]};
            else if (bus_addr == PROD_OFF)
                rdata_nxt = prod_r;
            else
                rdata_nxt = 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            acc_a_r   <= ACC_RST;                     // RULE23
            acc_b_r   <= ACC_RST;
            prod_r    <= 32'h00000000;
            pvld_r    <= 1'b0;
            ctrl_r    <= CTRL_RST;
            trap_en_r <= TRAP_RST;
            stat_r    <= STAT_RST;
            trap_r    <= 1'b0;
            rdata_r   <= 32'h00000000;
        end
        else
        begin
            acc_a_r   <= acc_a_nxt;
            acc_b_r   <= acc_b_nxt;
            prod_r    <= prod_nxt;
            pvld_r    <= pvld_nxt;
            ctrl_r    <= ctrl_nxt;
            trap_en_r <= trap_en_nxt;
            stat_r    <= stat_nxt;                    // RULE14
            trap_r    <= trap_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign acc_a       = acc_a_r;
    assign acc_b       = acc_b_r;
    assign prod_result = prod_r;
    assign prod_valid  = pvld_r;
    assign status_bits = stat_r;
    assign arith_trap  = trap_r;
    assign bus_rdata   = rdata_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_clip_a_op;
        is_add_op && !req.acc_sel && clip_en &&
        !ctrl_r[CC_WIDTH_BIT] && (ovf31 || cat_ovf);
    endsequence

    sequence s_clamped_a;
        ((acc_a == POS31) || (acc_a == NEG31)) && status_bits[ST_CLIP_A];
    endsequence

    property p_clip_a;
        s_clip_a_op |=> s_clamped_a;
    endproperty

    a_clip_a_clamp: assert property (p_clip_a) // RULE17
        else $error("Accumulator A not clamped at 1.31 width.");

    a_mpy_load_a: assert property ( // RULE3
        req_valid && req.op == OP_MPY && !req.acc_sel && !clip_en
        |=> acc_a == {{7{$past(prod33[32])}}, $past(prod33)})
        else $error("Product not sign-extended into accumulator A.");

    a_msc_subtract: assert property ( // RULE11
        req_valid && req.op == OP_MSC && !clip_en
        |=> ($past(req.acc_sel) ? acc_b : acc_a) ==
            40'($past(src) - $past(prod40)))
        else $error("Subtract into the selected accumulator is wrong.");

    a_guard_ovf_a: assert property ( // RULE13
        req_valid && is_add_op && !req.acc_sel
        |=> status_bits[ST_OVF_A] ==
            !((&$past(sum41[39:32])) || !(|$past(sum41[39:32]))))
        else $error("Guard overflow flag A does not follow result.");

    a_any_flags_or: assert property ( // RULE19
        status_bits[ST_ANY_OVF] ==
            (status_bits[ST_OVF_A] | status_bits[ST_OVF_B]) &&
        status_bits[ST_ANY_CLIP] ==
            (status_bits[ST_CLIP_A] | status_bits[ST_CLIP_B]))
        else $error("Combined flags are not the OR of the pair.");

    a_trap_raise: assert property ( // RULE21
        arith_trap == ((status_bits[ST_OVF_A] & trap_en_r[0]) |
                       (status_bits[ST_OVF_B] & trap_en_r[1])))
        else $error("Arithmetic trap disagrees with flags and enables.");

    a_byte_mul_width: assert property ( // RULE7
        req_valid && req.op == OP_MUL && req.byte_mode
        |=> prod_valid && prod_result[31:16] == 16'h0000)
        else $error("Byte multiply result wider than 16 bits.");

    a_frac_minus_one: assert property ( // RULE4
        req_valid && req.op == OP_MPY && req.frac && !req.acc_sel &&
        req.a_signed && req.b_signed && !clip_en &&
        req.opnd_a == 16'h8000 && req.opnd_b == 16'h8000
        |=> acc_a == 40'h0080000000)
        else $error("Fractional -1 times -1 gave wrong 1.31 value.");

    a_status_read: assert property ( // RULE14
        bus_rd && bus_addr == STATUS_OFF
        |=> bus_rdata == {24'h000000, $past(status_bits)})
        else $error("Status read data wrong one cycle later.");

    a_clip_flag_hold: assert property ( // RULE20
        !req_valid && !bus_wr |=> $stable(status_bits))
        else $error("Status flags changed without an operation.");

endmodule : mac_datapath

// *** verilog/mac_pkg.sv ***
// Purpose: Shared constants and types for the DSP multiply-accumulate datapath.
// Assumes: One 25 MHz core clock, synchronous active-low reset.
// Notes:   Offsets are byte addresses on the plain register port.
package mac_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ACC_W  = 40;
    localparam int MUL_W  = 17;
    localparam int PROD_W = 33;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CORE_CTRL_OFF = 8'h00;
    localparam logic [7:0] INT_CTRL_OFF  = 8'h04;
    localparam logic [7:0] STATUS_OFF    = 8'h08;
    localparam logic [7:0] ACCA_LO_OFF   = 8'h0c;
    localparam logic [7:0] ACCA_HI_OFF   = 8'h10;
    localparam logic [7:0] ACCB_LO_OFF   = 8'h14;
    localparam logic [7:0] ACCB_HI_OFF   = 8'h18;
    localparam logic [7:0] PROD_OFF      = 8'h1c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CC_CLIP_A_BIT = 7;
    localparam int CC_CLIP_B_BIT = 6;
    localparam int CC_WIDTH_BIT  = 4;
    localparam int IC_TRAP_A_BIT = 0;
    localparam int IC_TRAP_B_BIT = 1;
    localparam int ST_OVF_A      = 0;
    localparam int ST_OVF_B      = 1;
    localparam int ST_CLIP_A     = 2;
    localparam int ST_CLIP_B     = 3;
    localparam int ST_ANY_OVF    = 4;
    localparam int ST_ANY_CLIP   = 5;
    localparam int ST_CAT_A      = 6;
    localparam int ST_CAT_B      = 7;

    // ----------------------------------------------------------------
    // Reset and clamp values
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [1:0]  TRAP_RST = 2'h0;
    localparam logic [7:0]  STAT_RST = 8'h00;
    localparam logic [39:0] ACC_RST  = 40'h0000000000;
    localparam logic [39:0] POS31    = 40'h007fffffff;
    localparam logic [39:0] NEG31    = 40'hff80000000;
    localparam logic [39:0] POS39    = 40'h7fffffffff;
    localparam logic [39:0] NEG39    = 40'h8000000000;

    // ----------------------------------------------------------------
    // Operation request
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_IDLE     = 3'b000,
        OP_MPY      = 3'b001,
        OP_MAC      = 3'b010,
        OP_MSC      = 3'b011,
        OP_ADD      = 3'b100,
        OP_LOAD_ACC = 3'b101,
        OP_MUL      = 3'b110
    } mac_op_type;

    typedef struct packed {
        mac_op_type  op;
        logic        acc_sel;
        logic [15:0] opnd_a;
        logic [15:0] opnd_b;
        logic        a_signed;
        logic        b_signed;
        logic        frac;
        logic        byte_mode;
        logic [15:0] data;
        logic [4:0]  shift;
    } mac_req_type;

endpackage : mac_pkg

// *** sim/mac_ctrl_model.sv ***
// Purpose: Instruction control and working register model for the datapath.
// Assumes: One request per cycle, held until the edge that takes it.
// Notes:   Idle request lines carry inverted data so stale values show.
`timescale 1ns/1ps
module mac_ctrl_model (
    // Clock
    input  wire logic            clk,
    // Request to the datapath
    output logic                 req_valid,
    output mac_pkg::mac_req_type req,
    // Product return
    input  wire logic [31:0]     prod_result,
    input  wire logic            prod_valid,
    output logic      [31:0]     wreg
);
    import mac_pkg::*;
    // ----------------------------------------------------------------
    // Working register and request driver
    // ----------------------------------------------------------------
    initial
    begin
        req_valid = 1'h0;
        req       = '0;
        wreg      = 32'h0;
    end
    // The register loads only on the pulse, so a missed pulse shows up.
    always @(posedge clk)
    begin
        if (prod_valid)
            wreg <= prod_result;
    end
    task automatic issue(input mac_req_type r);
    begin
        @(posedge clk);
        req_valid <= 1'h1;
        req       <= r;
        @(posedge clk);
        req_valid <= 1'h0;
        req       <= ~r;
    end
    endtask : issue
endmodule : mac_ctrl_model

// *** sim/mac_datapath_tb_top.sv ***
// Purpose: Self-checking bench for the multiply-accumulate datapath.
// Assumes: One clock; requests and register accesses never overlap.
// Notes:   Flag expectations follow latest-op guard and sticky clip flags.
`timescale 1ns/1ps
module mac_datapath_tb_top;
    import mac_pkg::*;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic               clk, rstn, req_valid, bus_wr, bus_rd, prod_valid;
    logic               arith_trap;
    logic [7:0]         bus_addr, status_bits;
    logic [31:0]        bus_wdata, bus_rdata, prod_result, wreg, d;
    logic [39:0]        acc_a, acc_b;
    logic signed [33:0] pw;
    logic signed [17:0] pb;
    mac_req_type        req;
    int                 num_errors, check_count, cyc;
    mac_datapath mac_datapath_inst (
        .clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .acc_a(acc_a),
        .acc_b(acc_b), .prod_result(prod_result),
        .prod_valid(prod_valid), .status_bits(status_bits),
        .arith_trap(arith_trap)
    );
    mac_ctrl_model mac_ctrl_model_inst (
        .clk(clk), .req_valid(req_valid), .req(req),
        .prod_result(prod_result), .prod_valid(prod_valid), .wreg(wreg)
    );
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // The whole run needs about 110 cycles; the ceiling leaves slack.
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 4000)
        begin
            num_errors = num_errors + 1;
            close_out();
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk_acc(input logic [39:0] g, e);
    begin
        check_count = check_count + 1;
        if (g !== e)
        begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    end
    endtask : chk_acc
    task automatic chk_word(input logic [31:0] g, e);
    begin
        chk_acc({8'h0, g}, {8'h0, e});
    end
    endtask : chk_word
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
    begin
        @(posedge clk);
        bus_wr    <= 1'h1;
        bus_addr  <= a;
        bus_wdata <= v;
        @(posedge clk);
        bus_wr    <= 1'h0;
        bus_wdata <= ~v;
    end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
    begin
        @(posedge clk);
        bus_rd   <= 1'h1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd   <= 1'h0;
        #1 chk_word(bus_rdata, e);
    end
    endtask : rd
    task automatic run(input mac_op_type o, input logic s,
                       input logic [15:0] a, b, input logic [3:0] f,
                       input logic [15:0] v, input logic [4:0] sh);
        mac_req_type r;
    begin
        r = '{o, s, a, b, f[3], f[2], f[1], f[0], v, sh};
        mac_ctrl_model_inst.issue(r);
    end
    endtask : run
    task automatic fin(input logic s, input logic [39:0] ea,
                       input logic [8:0] es);
    begin
        #1 chk_acc(s ? acc_b : acc_a, ea);
        chk_word({23'h0, arith_trap, status_bits}, {23'h0, es});
    end
    endtask : fin
    task automatic mp(input mac_op_type o, input logic s,
                      input logic [15:0] a, b, input logic [3:0] f,
                      input logic [39:0] ea, input logic [8:0] es);
    begin
        run(o, s, a, b, f, 16'h0, 5'h0);
        fin(s, ea, es);
    end
    endtask : mp
    task automatic ld(input mac_op_type o, input logic s,
                      input logic [15:0] v, input logic [4:0] sh,
                      input logic [39:0] ea, input logic [8:0] es);
    begin
        run(o, s, 16'h0, 16'h0, 4'h0, v, sh);
        fin(s, ea, es);
    end
    endtask : ld
    task automatic close_out;
    begin
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask : close_out
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rstn = 1'h0;
        bus_wr = 1'h0;
        bus_rd = 1'h0;
        bus_addr = 8'h0;
        bus_wdata = 32'h0;
        num_errors = 0;
        check_count = 0;
        cyc = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        for (int i = 0; i < 9; i++)
            rd(8'(i * 4), 32'h0);
        mp(OP_MPY,1'h0,16'h8000,16'h8000,4'he,40'h0080000000,9'h0);
        mp(OP_MAC,1'h0,16'h4000,16'h4000,4'he,40'h00a0000000,9'h0);
        mp(OP_MSC,1'h0,16'h4000,16'hc000,4'he,40'h00c0000000,9'h0);
        mp(OP_MPY,1'h1,16'hffff,16'hffff,4'h0,40'h00fffe0001,9'h0);
        ld(OP_LOAD_ACC,1'h0,16'h8000,5'h04,40'hfff8000000,9'h0);
        ld(OP_ADD,1'h0,16'h0001,5'h00,40'hfff8010000,9'h0);
        wr(INT_CTRL_OFF, 32'h1);
        rd(INT_CTRL_OFF, 32'h1);
        ld(OP_LOAD_ACC,1'h0,16'h7fff,5'h18,40'h7fff000000,9'h111);
        ld(OP_ADD,1'h1,16'h0000,5'h00,40'h00fffe0001,9'h111);
        ld(OP_LOAD_ACC,1'h0,16'h0001,5'h00,40'h0000010000,9'h000);
        ld(OP_LOAD_ACC,1'h0,16'h7fff,5'h18,40'h7fff000000,9'h111);
        ld(OP_ADD,1'h0,16'h7fff,5'h18,40'hfffe000000,9'h040);
        wr(CORE_CTRL_OFF, 32'h80);
        ld(OP_LOAD_ACC,1'h0,16'h7fff,5'h18,40'h007fffffff,9'h135);
        ld(OP_LOAD_ACC,1'h0,16'h8000,5'h18,40'hff80000000,9'h135);
        ld(OP_LOAD_ACC,1'h0,16'h0040,5'h00,40'h0000400000,9'h024);
        wr(STATUS_OFF, 32'h4);
        rd(STATUS_OFF, 32'h0);
        wr(CORE_CTRL_OFF, 32'hd0);
        rd(CORE_CTRL_OFF, 32'hd0);
        ld(OP_LOAD_ACC,1'h0,16'h7fff,5'h18,40'h7fff000000,9'h111);
        ld(OP_ADD,1'h0,16'h7fff,5'h18,40'h7fffffffff,9'h064);
        wr(ACCA_LO_OFF, 32'h0);
        rd(ACCA_LO_OFF, 32'hffffffff);
        rd(ACCA_HI_OFF, 32'h7f);
        ld(OP_LOAD_ACC,1'h1,16'h8000,5'h18,40'h8000000000,9'h076);
        ld(OP_ADD,1'h1,16'h8000,5'h18,40'h8000000000,9'h0ec);
        rd(STATUS_OFF, 32'hec);
        // Both operands have their top and byte sign bits set on purpose.
        for (int i = 0; i < 8; i++)
        begin
            run(OP_MUL, 1'h0, 16'hff85, 16'h8083, {i[1:0], 1'h0, i[2]},
                16'h0, 5'h0);
            pw = $signed({i[1], 16'hff85}) * $signed({i[0], 16'h8083});
            pb = $signed({i[1], 8'h85}) * $signed({i[0], 8'h83});
            d = i[2] ? {16'h0, pb[15:0]} : pw[31:0];
            #1 chk_word(prod_result, d);
            chk_word({31'h0, prod_valid}, 32'h1);
        end
        @(posedge clk);
        #1 chk_word(wreg, d);
        chk_word({31'h0, prod_valid}, 32'h0);
        rd(PROD_OFF, d);
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        #1 chk_acc(acc_b, 40'h0);
        chk_word({23'h0, arith_trap, status_bits}, 32'h0);
        rd(CORE_CTRL_OFF, 32'h0);
        close_out();
    end
endmodule : mac_datapath_tb_top
